//--- rtl/scc_pkg.sv
// Overview of operation
// R01: Latch five address straps; bit4 is MSB.
// R02: Address readable in extended status bits 4:0.
// R03: Full_duplex_indicator lit only on full-duplex link.
// R04: Multi-node strap selects master or slave priority.
// R05: Multi-node strap readable in status bit 5.
// R06: Trigger output only in test modes 1, 4.
// R07: Pair-swap strap high enables automatic crossover.
// R08: Strap low: crossover follows manual strap.
// R09: Pair-swap status bit 6; seeds ext bit 15.
// R10: Clock-to-MAC strap enables or disables clock output.
// R11: Clock-to-MAC strap readable in status bit 7.
// R12: Test mode 1: sync clock is test clock/4.
// R13: Test mode 4: divide by 6, else unavailable.
// R14: Reset source holds reset low at least 150 us.
// R15: Sample straps in reset, hold after release.
package scc_pkg;

  localparam int unsigned ADDR_W          = 5;
  localparam int unsigned REG_W           = 16;
  localparam int unsigned MODE_W          = 3;
  localparam int unsigned DIV_W           = 2;

  localparam logic [7:0]  STRAP_STS_ADDR  = 8'h10;
  localparam logic [7:0]  EXT_STS_ADDR    = 8'h12;
  localparam int unsigned STS_MULTI_BIT   = 5;
  localparam int unsigned STS_XOVER_BIT   = 6;
  localparam int unsigned STS_MACCLK_BIT  = 7;
  localparam int unsigned EXT_ADDR_LSB    = 0;
  localparam int unsigned EXT_XOVER_BIT   = 15;
  localparam logic [15:0] STS_RESET_VAL   = 16'h0000;

  localparam logic [2:0]  TEST_MODE_1     = 3'h1;
  localparam logic [2:0]  TEST_MODE_4     = 3'h4;
  // Half periods in test clock edges: divide by 4 and by 6.
  localparam logic [1:0]  HALF_DIV4       = 2'h2;
  localparam logic [1:0]  HALF_DIV6       = 2'h3;

  localparam longint      CLK_HZ          = 64'd20000000;
  localparam longint      RESET_MIN_US    = 64'd150;
  localparam int unsigned RST_CNT_W       = 12;
  localparam logic [11:0] RESET_MIN_CYC   = 12'((RESET_MIN_US * CLK_HZ + 64'd999999) / 64'd1000000);

  // Strap vector positions after the pin synchronisers.
  localparam int unsigned PIN_MULTI       = 5;
  localparam int unsigned PIN_AUTO        = 6;
  localparam int unsigned PIN_MANUAL      = 7;
  localparam int unsigned PIN_MACCLK      = 8;
  localparam int unsigned PIN_TCLK        = 9;
  localparam int unsigned PIN_W           = 10;

endpackage : scc_pkg

//--- rtl/scc_strap_capture.sv
module scc_strap_capture
  import scc_pkg::*;
(
  input  wire logic                      CORE_CLK,             // 20 MHz core clock.
  input  wire logic                      RSTN,                 // Synchronous hard reset, active low.
  input  wire logic                      CLK_EN,               // Freezes all state while low.
  input  wire logic [scc_pkg::ADDR_W-1:0] ADDR_STRAP_I,        // Address strap pins, bit 0 shared with LED.
  output logic                           ADDR0_PIN_O,          // Full duplex indicator drive.
  output logic                           ADDR0_PIN_OE_N,       // Low while the LED pin is driven.
  input  wire logic                      MULTI_PIN_I,          // Multi-node strap pin.
  output logic                           MULTI_PIN_O,          // Test trigger drive.
  output logic                           MULTI_PIN_OE_N,       // Low while trigger is driven.
  input  wire logic                      AUTO_XOVER_STRAP_I,   // Automatic pair swap strap.
  input  wire logic                      MANUAL_XOVER_STRAP_I, // Manual crossover strap.
  input  wire logic                      MACCLK_PIN_I,         // Clock-to-MAC strap pin.
  output logic                           MACCLK_PIN_O,         // Test sync clock drive.
  output logic                           MACCLK_PIN_OE_N,      // Low while sync clock is driven.
  input  wire logic                      TX_TEST_CLK,          // Transmit test clock, asynchronous.
  input  wire logic [scc_pkg::MODE_W-1:0] TEST_MODE,           // Gigabit transmit test mode.
  input  wire logic                      LINK_UP,              // Link established.
  input  wire logic                      FULL_DUPLEX,          // Operating in full duplex.
  input  wire logic                      AUTO_SWAP_DECISION,   // Pair swap chosen by crossover logic.
  input  wire logic                      EXT_XOVER_WR,         // Software write of ext bit 15.
  input  wire logic                      EXT_XOVER_WDATA,      // Value written to ext bit 15.
  output logic [scc_pkg::ADDR_W-1:0]     MGMT_BASE_ADDRESS,    // Latched management address.
  output logic [scc_pkg::REG_W-1:0]      STRAP_STATUS,         // Strap status register image.
  output logic [scc_pkg::REG_W-1:0]      EXT_STATUS,           // Extended status register image.
  output logic                           ADVERTISE_MULTI_NODE, // Master priority advertised.
  output logic                           AUTO_XOVER_EN,        // Automatic crossover enabled.
  output logic                           PAIR_SWAP,            // Media pairs swapped.
  output logic                           MAC_CLK_OUT_EN,       // Clock toward MAC enabled.
  output logic                           RESET_TIME_OK         // Last reset met minimum width.
);

  import scc_pkg::*;

  // Synchronisers run without reset so straps are sampled during reset.
  logic [PIN_W-1:0]     sync1_reg, sync2_reg;
  logic                 tclk_d_reg;
  logic                 tclk_rise;

  logic [ADDR_W-1:0]    addr_reg, addr_next;
  logic                 multi_reg, multi_next;
  logic                 auto_reg, auto_next;
  logic                 manual_reg, manual_next;
  logic                 macclk_reg, macclk_next;
  logic                 xover_reg, xover_next;
  logic                 drive_reg, drive_next;
  logic [RST_CNT_W-1:0] rcnt_reg, rcnt_next;
  logic                 in_rst_reg, in_rst_next;
  logic                 rok_reg, rok_next;

  logic [REG_W-1:0]     sts_reg, sts_next;
  logic [REG_W-1:0]     ext_reg, ext_next;
  logic                 led_reg, led_next;
  logic                 led_oe_n_reg, led_oe_n_next;
  logic                 swap_reg, swap_next;
  logic                 trig_o_reg, trig_o_next;
  logic                 sclk_o_reg, sclk_o_next;
  logic                 multi_oe_n_reg, multi_oe_n_next;
  logic                 mclk_oe_n_reg, mclk_oe_n_next;

  logic                 tm1, tm4, test_on;
  logic                 div_clk, div_trig;

  // Only these two test modes hand the shared pins over to the test outputs.
  // The same decode guards the pin enables and the trigger and sync-on checks, so it lives in one place.
  function automatic logic is_test_mode(input logic [MODE_W-1:0] mode);
    return (mode == TEST_MODE_1) || (mode == TEST_MODE_4);
  endfunction : is_test_mode

  always_ff @(posedge CORE_CLK) begin
    if (CLK_EN) begin
      sync1_reg  <= {TX_TEST_CLK, MACCLK_PIN_I, MANUAL_XOVER_STRAP_I, AUTO_XOVER_STRAP_I, MULTI_PIN_I, ADDR_STRAP_I};
      sync2_reg  <= sync1_reg;
      tclk_d_reg <= sync2_reg[PIN_TCLK];
    end
  end

  assign tclk_rise = sync2_reg[PIN_TCLK] && !tclk_d_reg;
  assign tm1       = (TEST_MODE == TEST_MODE_1);
  assign tm4       = (TEST_MODE == TEST_MODE_4);
  assign test_on   = drive_reg && is_test_mode(TEST_MODE);                       // R06

  scc_sync_div u_div (
    .clk       (CORE_CLK),
    .rst_n     (RSTN),
    .ce        (CLK_EN),
    .run       (test_on),                                                        // R13
    .half      (tm1 ? HALF_DIV4 : HALF_DIV6),                                    // R12
    .tclk_rise (tclk_rise),
    .sync_clk  (div_clk),
    .trigger   (div_trig)
  );

  // Strap latches follow the pins throughout reset and freeze at release.
  always_comb begin
    addr_next   = addr_reg;
    multi_next  = multi_reg;
    auto_next   = auto_reg;
    manual_next = manual_reg;
    macclk_next = macclk_reg;
    drive_next  = 1'b1;
    if (!RSTN) begin
      addr_next   = sync2_reg[ADDR_W-1:0];                                       // R01
      multi_next  = sync2_reg[PIN_MULTI];                                        // R15
      auto_next   = sync2_reg[PIN_AUTO];
      manual_next = sync2_reg[PIN_MANUAL];
      macclk_next = sync2_reg[PIN_MACCLK];
      drive_next  = 1'b0;                                                        // R15
    end
  end

  // Reset width check: a short pulse may leave straps unsettled.
  // The count restarts on the first edge of each reset and is kept after release, so the
  // status bit always agrees with the width that produced it.
  // An unknown entry flag at power-up falls to the restart branch, which keeps the count
  // out of the unknown state from the very first reset on.
  always_comb begin
    rcnt_next   = rcnt_reg;
    in_rst_next = !RSTN;
    rok_next    = rok_reg;
    if (!RSTN) begin
      rok_next = 1'b0;
      if (in_rst_reg) begin
        rcnt_next = (rcnt_reg >= RESET_MIN_CYC) ? rcnt_reg : rcnt_reg + 12'h001; // R14
      end else begin
        rcnt_next = 12'h001;                                                     // R14
      end
    end else if (in_rst_reg) begin
      rok_next = (rcnt_reg >= RESET_MIN_CYC);                                    // R14
    end
  end

  // Register images and functional outputs.
  always_comb begin
    xover_next = xover_reg;
    if (!RSTN) begin
      xover_next = sync2_reg[PIN_AUTO];                                          // R09
    end else if (EXT_XOVER_WR) begin
      xover_next = EXT_XOVER_WDATA;                                              // R09
    end
    sts_next                 = STS_RESET_VAL;
    sts_next[STS_MULTI_BIT]  = multi_next;                                       // R05
    sts_next[STS_XOVER_BIT]  = auto_next;                                        // R09
    sts_next[STS_MACCLK_BIT] = macclk_next;                                      // R11
    ext_next                 = STS_RESET_VAL;
    ext_next[EXT_ADDR_LSB +: ADDR_W] = addr_next;                                // R02
    ext_next[EXT_XOVER_BIT]  = xover_next;                                       // R09
    led_next  = RSTN && LINK_UP && FULL_DUPLEX;                                  // R03
    // The LED pin is released during reset so its strap resistor sets the level.
    led_oe_n_next   = !drive_next;                                               // R15
    swap_next = xover_next ? AUTO_SWAP_DECISION : manual_next;                   // R07 R08
    trig_o_next     = test_on && div_trig;                                       // R06
    multi_oe_n_next = !test_on;                                                  // R06
    sclk_o_next     = test_on && div_clk;                                        // R12 R13
    mclk_oe_n_next  = !test_on;                                                  // R13
  end

  always_ff @(posedge CORE_CLK) begin
    if (CLK_EN) begin
      addr_reg       <= addr_next;
      multi_reg      <= multi_next;
      auto_reg       <= auto_next;
      manual_reg     <= manual_next;
      macclk_reg     <= macclk_next;
      xover_reg      <= xover_next;
      drive_reg      <= drive_next;
      rcnt_reg       <= rcnt_next;
      in_rst_reg     <= in_rst_next;
      rok_reg        <= rok_next;
      sts_reg        <= sts_next;
      ext_reg        <= ext_next;
      led_reg        <= led_next;
      led_oe_n_reg   <= led_oe_n_next;
      swap_reg       <= swap_next;
      trig_o_reg     <= trig_o_next;
      sclk_o_reg     <= sclk_o_next;
      multi_oe_n_reg <= multi_oe_n_next;
      mclk_oe_n_reg  <= mclk_oe_n_next;
    end
  end

  assign MGMT_BASE_ADDRESS    = addr_reg;                                        // R01
  assign STRAP_STATUS         = sts_reg;
  assign EXT_STATUS           = ext_reg;
  assign ADVERTISE_MULTI_NODE = multi_reg;                                       // R04
  assign AUTO_XOVER_EN        = xover_reg;                                       // R07
  assign PAIR_SWAP            = swap_reg;
  assign MAC_CLK_OUT_EN       = macclk_reg;                                      // R10
  assign RESET_TIME_OK        = rok_reg;
  assign ADDR0_PIN_O          = led_reg;
  assign ADDR0_PIN_OE_N       = led_oe_n_reg;                                    // R15
  assign MULTI_PIN_O          = trig_o_reg;
  assign MULTI_PIN_OE_N       = multi_oe_n_reg;
  assign MACCLK_PIN_O         = sclk_o_reg;
  assign MACCLK_PIN_OE_N      = mclk_oe_n_reg;

  // Checks: reset is the disable, so strap capture itself is seen at release.
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  addr_hold_a: assert property (CLK_EN && $past(RSTN) |=> $stable(MGMT_BASE_ADDRESS)) // R15
    else $error("Address changed after reset release.");
  addr_image_a: assert property (EXT_STATUS[4:0] == MGMT_BASE_ADDRESS) // R02
    else $error("Extended status address mismatch.");
  multi_image_a: assert property (STRAP_STATUS[5] == ADVERTISE_MULTI_NODE) // R05
    else $error("Multi-node status bit mismatch.");
  macclk_image_a: assert property (STRAP_STATUS[7] == MAC_CLK_OUT_EN) // R11
    else $error("Clock-to-MAC status bit mismatch.");
  xover_image_a: assert property (EXT_STATUS[15] == AUTO_XOVER_EN) // R09
    else $error("Ext bit 15 does not steer crossover.");
  xover_write_a: assert property (CLK_EN && EXT_XOVER_WR |=> AUTO_XOVER_EN == $past(EXT_XOVER_WDATA)) // R09
    else $error("Software crossover write lost.");
  // A write in the same cycle changes the steering, so both swap checks leave that cycle out.
  manual_swap_a: assert property (CLK_EN && $past(RSTN) && !EXT_XOVER_WR && !AUTO_XOVER_EN |=> PAIR_SWAP == manual_reg) // R08
    else $error("Manual crossover not followed.");
  auto_swap_a: assert property (CLK_EN && !EXT_XOVER_WR && AUTO_XOVER_EN |=> PAIR_SWAP == $past(AUTO_SWAP_DECISION)) // R07
    else $error("Automatic pair swap decision not followed.");
  // While the clock enable is low every output holds, so inputs seen then prove nothing.
  led_lit_a: assert property ($past(CLK_EN) && ADDR0_PIN_O |-> $past(LINK_UP) && $past(FULL_DUPLEX)) // R03
    else $error("Full_duplex_indicator lit without full-duplex link.");
  led_off_a: assert property (CLK_EN && !(LINK_UP && FULL_DUPLEX) |=> !ADDR0_PIN_O) // R03
    else $error("Full_duplex_indicator still lit after the link or full duplex dropped.");
  led_drive_a: assert property ($past(CLK_EN) && $past(RSTN) |-> !ADDR0_PIN_OE_N) // R15
    else $error("Full_duplex_indicator pin not driven after reset release.");
  strap_hold_a: assert property (CLK_EN && $past(RSTN) |=> $stable(MAC_CLK_OUT_EN) && $stable(ADVERTISE_MULTI_NODE)) // R10 R04
    else $error("Latched strap changed after reset release.");
  trig_mode_a: assert property ($past(CLK_EN) && (!MULTI_PIN_OE_N || MULTI_PIN_O) |-> $past(is_test_mode(TEST_MODE))) // R06
    else $error("Trigger driven outside test modes 1 and 4.");
  trig_pulse_a: assert property (CLK_EN && MULTI_PIN_O |=> !MULTI_PIN_O) // R06
    else $error("Trigger pulse longer than one cycle.");
  sync_on_a: assert property (CLK_EN && $past(CLK_EN) && $past(RSTN) && is_test_mode(TEST_MODE) |=> !MACCLK_PIN_OE_N && !MULTI_PIN_OE_N) // R12
    else $error("Test outputs not driven in test modes 1 and 4.");
  rok_low_a: assert property ($past(CLK_EN) && !$past(RSTN) |-> !RESET_TIME_OK) // R14
    else $error("Reset width flag set while reset is held.");
  sync_off_a: assert property (CLK_EN && !(tm1 || tm4) |=> MACCLK_PIN_OE_N && !MACCLK_PIN_O) // R13
    else $error("Sync clock present outside test modes.");
  rst_ok_a: assert property (RESET_TIME_OK |-> rcnt_reg >= RESET_MIN_CYC) // R14
    else $error("Reset accepted shorter than minimum.");

  div4_cov: cover property (tm1 && $rose(MACCLK_PIN_O));
  div6_cov: cover property (tm4 && $rose(MULTI_PIN_O));
  xover_cov: cover property (EXT_XOVER_WR && EXT_XOVER_WDATA != AUTO_XOVER_EN);
  led_cov: cover property ($rose(ADDR0_PIN_O));
  rok_cov: cover property ($rose(RESET_TIME_OK));

endmodule : scc_strap_capture

//--- rtl/scc_sync_div.sv
module scc_sync_div
  import scc_pkg::*;
(
  input  wire logic             clk,       // Core clock.
  input  wire logic             rst_n,     // Synchronous reset, active low.
  input  wire logic             ce,        // Clock enable.
  input  wire logic             run,       // Divider active.
  input  wire logic [DIV_W-1:0] half,      // Test clock edges per half period.
  input  wire logic             tclk_rise, // One-cycle test clock rising edge.
  output logic                  sync_clk,  // Divided clock.
  output logic                  trigger    // Pulse at each divided rising edge.
);

  logic [DIV_W-1:0] cnt_reg, cnt_next;
  logic             clk_reg, clk_next;
  logic             trig_reg, trig_next;

  always_comb begin
    cnt_next  = cnt_reg;
    clk_next  = clk_reg;
    trig_next = 1'b0;
    if (!rst_n || !run) begin
      cnt_next = '0;
      clk_next = 1'b0;
    end else if (tclk_rise) begin
      if (cnt_reg == half - 2'h1) begin
        cnt_next  = '0;
        clk_next  = !clk_reg;
        trig_next = !clk_reg;
      end else begin
        cnt_next = cnt_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      cnt_reg  <= cnt_next;
      clk_reg  <= clk_next;
      trig_reg <= trig_next;
    end
  end

  assign sync_clk = clk_reg;
  assign trigger  = trig_reg;

endmodule : scc_sync_div

//--- verif/scc_board_model.sv
module scc_board_model
  import scc_pkg::*;
#(
  parameter int HOLD_CYC = 3100
) (
  input  wire logic              clk,      // Core clock.
  input  wire logic              rst_req,  // Request a full-width reset.
  input  wire logic [PIN_MACCLK:0] straps, // Strap resistor levels.
  input  wire logic [2:0]        pin_o,    // Device drive: LED, trigger, sync clock.
  input  wire logic [2:0]        pin_oe_n, // Device enables, low while driving.
  output logic                   rstn_o,   // Reset source output, active low.
  output logic [PIN_MACCLK:0]    pins      // Levels seen on the strap pins.
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [11:0] hold_reg = 12'h000;

  // The source never lets go early, so every requested reset meets the minimum width.
  always_ff @(posedge clk) begin
    if (rst_req) begin
      hold_reg <= 12'(HOLD_CYC);
    end else if (hold_reg != 12'h000) begin
      hold_reg <= hold_reg - 12'h001;
    end
  end
  assign rstn_o = (hold_reg == 12'h000);

  // A resistor only sets the level while the device leaves the shared pin undriven.
  always_comb begin
    pins = straps;
    if (!pin_oe_n[0]) pins[0] = pin_o[0];
    if (!pin_oe_n[1]) pins[PIN_MULTI] = pin_o[1];
    if (!pin_oe_n[2]) pins[PIN_MACCLK] = pin_o[2];
  end
endmodule : scc_board_model

//--- verif/test_strap_config_capture.sv
module test_strap_config_capture;
  import scc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0, bench_rstn = 1'b0, rst_req = 1'b0, tx_clk = 1'b0, clk_en = 1'b1;
  logic link = 1'b0, fdx = 1'b0, swap_dec = 1'b0, wr = 1'b0, wdata = 1'b0, rstn, model_rstn;
  logic [MODE_W-1:0]   mode = 3'h0;
  logic [PIN_MACCLK:0] straps = 9'h155, pins;
  wire logic [2:0]     pin_o, pin_oe_n;
  logic [ADDR_W-1:0]   mgmt;
  logic [REG_W-1:0]    sts, ext;
  logic                adv, axen, pswap, mcen, rok;
  int                  n_fail = 0, total_checks = 0;

  assign rstn = bench_rstn & model_rstn;
  always #25 clk = ~clk;
  // Half period chosen so test clock edges never meet a rising core clock edge.
  always #212 tx_clk = ~tx_clk;

  scc_board_model i_scc_board_model (.clk(clk), .rst_req(rst_req), .straps(straps), .pin_o(pin_o),
    .pin_oe_n(pin_oe_n), .rstn_o(model_rstn), .pins(pins));

  scc_strap_capture i_scc_strap_capture (.CORE_CLK(clk), .RSTN(rstn), .CLK_EN(clk_en),
    .ADDR_STRAP_I(pins[4:0]), .ADDR0_PIN_O(pin_o[0]), .ADDR0_PIN_OE_N(pin_oe_n[0]),
    .MULTI_PIN_I(pins[PIN_MULTI]), .MULTI_PIN_O(pin_o[1]), .MULTI_PIN_OE_N(pin_oe_n[1]),
    .AUTO_XOVER_STRAP_I(pins[PIN_AUTO]), .MANUAL_XOVER_STRAP_I(pins[PIN_MANUAL]),
    .MACCLK_PIN_I(pins[PIN_MACCLK]), .MACCLK_PIN_O(pin_o[2]), .MACCLK_PIN_OE_N(pin_oe_n[2]),
    .TX_TEST_CLK(tx_clk), .TEST_MODE(mode), .LINK_UP(link), .FULL_DUPLEX(fdx),
    .AUTO_SWAP_DECISION(swap_dec), .EXT_XOVER_WR(wr), .EXT_XOVER_WDATA(wdata),
    .MGMT_BASE_ADDRESS(mgmt), .STRAP_STATUS(sts), .EXT_STATUS(ext), .ADVERTISE_MULTI_NODE(adv),
    .AUTO_XOVER_EN(axen), .PAIR_SWAP(pswap), .MAC_CLK_OUT_EN(mcen), .RESET_TIME_OK(rok));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report

  task automatic t_straps(input logic [PIN_MACCLK:0] s, input logic long_rst);
    logic [15:0] st;
    st = {8'h00, s[PIN_MACCLK], s[PIN_AUTO], s[PIN_MULTI], 5'h00};
    @(posedge clk);
    straps <= s;
    if (long_rst) begin
      rst_req <= 1'b1;
      @(posedge clk);
      rst_req <= 1'b0;
      @(posedge clk);
      for (int i = 0; i < 4000 && rstn !== 1'b1; i++) @(posedge clk);
    end else begin
      bench_rstn <= 1'b0;
      repeat (10) @(posedge clk);
      check("reset drive", pin_oe_n, 3'h7);
      bench_rstn <= 1'b1;
    end
    repeat (3) @(posedge clk);
    @(negedge clk);
    check("address", mgmt, s[4:0]);
    check("strap status", sts, st);
    check("ext status", ext, {s[PIN_AUTO], 10'h000, s[4:0]});
    check("advertise", adv, s[PIN_MULTI]);
    check("auto xover", axen, s[PIN_AUTO]);
    check("pair swap", pswap, s[PIN_AUTO] ? swap_dec : s[PIN_MANUAL]);
    check("mac clock", mcen, s[PIN_MACCLK]);
    check("reset width", rok, long_rst);
    @(posedge clk);
    straps <= ~s;
    repeat (5) @(posedge clk);
    @(negedge clk);
    check("frozen address", mgmt, s[4:0]);
    check("frozen status", sts, st);
    $display("strap test done");
  endtask : t_straps

  task automatic t_xover(input logic man);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      wr <= 1'b1;
      wdata <= i[1];
      swap_dec <= i[0];
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      check("xover enable", {ext[15], axen}, {2{i[1]}});
      check("swap choice", pswap, i[1] ? i[0] : man);
    end
    $display("crossover test done");
  endtask : t_xover

  task automatic t_led;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      link <= i[0];
      fdx <= i[1];
      @(posedge clk);
      @(negedge clk);
      check("full_duplex_indicator", {pin_oe_n[0], pin_o[0]}, {1'b0, i[0] & i[1]});
    end
    @(posedge clk);
    clk_en <= 1'b0;
    link <= 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    check("frozen led", pin_o[0], 1'b1);
    @(posedge clk);
    clk_en <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check("led off", pin_o[0], 1'b0);
    $display("led test done");
  endtask : t_led

  // Counts test clock rises and trigger pulses up to the next sync clock rise.
  task automatic sync_edge(output int n_tx, output int n_trig);
    logic s_prev, t_prev;
    n_tx = 0;
    n_trig = 0;
    s_prev = pin_o[2];
    t_prev = tx_clk;
    for (int k = 0; k < 200; k++) begin
      @(posedge clk);
      if (tx_clk && !t_prev) n_tx++;
      if (pin_o[1] === 1'b1) n_trig++;
      t_prev = tx_clk;
      if (pin_o[2] && !s_prev) break;
      s_prev = pin_o[2];
    end
  endtask : sync_edge

  task automatic t_modes;
    int n_tx, n_trig;
    logic on;
    for (int m = 0; m < 8; m++) begin
      on = (m == 1 || m == 4);
      @(posedge clk);
      mode <= 3'(m);
      repeat (8) @(posedge clk);
      @(negedge clk);
      check("test drive", pin_oe_n[2:1], on ? 2'h0 : 2'h3);
      if (!on) check("idle pins", pin_o[2:1], 2'h0);
      if (on) begin
        sync_edge(n_tx, n_trig);
        sync_edge(n_tx, n_trig);
        check("sync divide", 16'(n_tx), m == 1 ? 16'h0004 : 16'h0006);
        check("trigger", 16'(n_trig), 16'h0001);
      end
    end
    @(posedge clk);
    mode <= 3'h0;
    $display("test mode test done");
  endtask : t_modes

  initial begin
    #(20000 * 50);
    n_fail++;
    $display("watchdog expired");
    final_report();
  end

  initial begin
    t_straps(9'h155, 1'b0);
    t_xover(1'b0);
    t_led();
    t_modes();
    t_straps(9'h0AA, 1'b1);
    final_report();
  end
endmodule : test_strap_config_capture
